// [operand_address_decoder.sv]
// Notes on behaviour
// [RULE1] Mode 00 reg, 01 indirect, 10 symbolic, 11 autoinc
// [RULE2] Byte bit one means byte, zero word
// [RULE3] Register fields pick workspace register 0..15
// [RULE4] Jump target is PC plus displacement bias
// [RULE5] Count field gives shift or serial-bit count
// [RULE6] Register mode operand is the register itself
// [RULE7] Byte register operand is the left byte
// [RULE8] Destination fields sit above source fields
// [RULE9] Indirect reads register, uses it as address
// [RULE10] Autoincrement adds one for byte, two word
// [RULE11] Indirect pointers come only from registers
// [RULE12] Symbolic, register zero: next word is address
// [RULE13] Source address word precedes destination word
// [RULE14] Symbolic nonzero register: address plus index
// [RULE15] Only symbolic operands are ever indexed
// [RULE16] Word addresses even; bytes step singly
// [RULE17] Copy writes source value into destination
// [RULE18] Workspace is sixteen words at pointer
// [RULE19] Instruction is one to three words
// [RULE20] Autoincrement uses old value, writes back new
// [RULE21] Register n lives at pointer plus 2n
`default_nettype none
module operand_address_decoder #(
  parameter int AXI_ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory holding workspace, instructions and operands
  output opaddr_pkg::mem_req_s mem_req,
  input wire opaddr_pkg::mem_rsp_s mem_rsp
);
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_DECODE, S_OPND, S_REG_RD, S_AUTO_WR, S_EXT_RD,
    S_IDX_RD, S_OPND_END, S_VAL_RD, S_DST_WR, S_DONE
  } seq_state_e;

  seq_state_e state;
  opaddr_pkg::instr_class_e iclass;
  logic [15:0] wp, pc, instr, ea, src_ea, dst_ea, src_val, target;
  logic [3:0] xfer_count;
  logic [15:0] mem_addr, mem_wdata;
  logic phase_dst, copy_en, done, start_pulse, done_clr;
  logic [7:0] aw_addr, ar_word;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held;
  logic byte_op, busy, do_write, wr_ok, rd_ok;
  logic [31:0] rd_data;
  opaddr_pkg::opnd_s src_info, dst_info, cur;
  logic [15:0] ea_aligned, val_sel;

  // Field extraction; destination fields sit in the upper positions
  assign byte_op = instr[opaddr_pkg::BYTE_BIT]; // [RULE2]
  assign busy = (state != S_IDLE);

  operand_field_decoder u_src_dec (
    .mode(instr[opaddr_pkg::SMODE_HI:opaddr_pkg::SMODE_LO]),
    .regn(instr[opaddr_pkg::SREG_HI:opaddr_pkg::SREG_LO]),
    .byte_op(byte_op),
    .wp(wp),
    .info(src_info)
  );

  operand_field_decoder u_dst_dec (
    .mode(instr[opaddr_pkg::DMODE_HI:opaddr_pkg::DMODE_LO]), // [RULE8]
    .regn(instr[opaddr_pkg::DREG_HI:opaddr_pkg::DREG_LO]),
    .byte_op(byte_op),
    .wp(wp),
    .info(dst_info)
  );

  assign cur = phase_dst ? dst_info : src_info;
  assign ea_aligned = byte_op ? ea : (ea & opaddr_pkg::WORD_MASK); // [RULE16]
  // Even byte address is the left half of the word
  assign val_sel = byte_op ? {8'h00, (ea[0] ? mem_rsp.rdata[7:0] : mem_rsp.rdata[15:8])} : mem_rsp.rdata; // [RULE7]

  // Memory request follows the state; address and data come from flops
  always_comb begin
    mem_req.valid = (state == S_FETCH) || (state == S_REG_RD) || (state == S_AUTO_WR) ||
                    (state == S_EXT_RD) || (state == S_IDX_RD) || (state == S_VAL_RD) ||
                    (state == S_DST_WR);
    mem_req.write = (state == S_AUTO_WR) || (state == S_DST_WR);
    mem_req.byte_op = byte_op && ((state == S_VAL_RD) || (state == S_DST_WR));
    mem_req.addr = mem_addr;
    mem_req.wdata = mem_wdata;
  end

  // Main sequencer and operand datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      iclass <= opaddr_pkg::IC_OTHER;
      instr <= 16'h0000;
      ea <= 16'h0000;
      src_ea <= 16'h0000;
      dst_ea <= 16'h0000;
      src_val <= 16'h0000;
      target <= 16'h0000;
      xfer_count <= 4'h0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      phase_dst <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_pulse) begin
            mem_addr <= pc;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_rsp.ready) begin
            instr <= mem_rsp.rdata; // [RULE19]
            state <= S_DECODE;
          end
        end
        S_DECODE: begin
          phase_dst <= 1'b0;
          if (instr[15:14] != opaddr_pkg::SINGLE_FMT_TOP) begin
            iclass <= opaddr_pkg::IC_TWO_OP;
            state <= S_OPND;
          end else if (instr[15:12] == opaddr_pkg::JUMP_PFX) begin
            iclass <= opaddr_pkg::IC_JUMP;
            // pc already points past the word; bias counts words
            target <= pc + {{7{instr[opaddr_pkg::DISP_HI]}}, instr[opaddr_pkg::DISP_HI:opaddr_pkg::DISP_LO], 1'b0}; // [RULE4]
            state <= S_DONE;
          end else if (instr[15:11] == opaddr_pkg::BIO_PFX) begin
            iclass <= opaddr_pkg::IC_BIT_IO;
            xfer_count <= instr[opaddr_pkg::BIO_CNT_HI:opaddr_pkg::BIO_CNT_LO]; // [RULE5]
            state <= S_OPND;
          end else if (instr[15:10] == opaddr_pkg::SHIFT_PFX) begin
            iclass <= opaddr_pkg::IC_SHIFT;
            xfer_count <= instr[opaddr_pkg::SH_CNT_HI:opaddr_pkg::SH_CNT_LO]; // [RULE5]
            state <= S_DONE;
          end else if (instr[15:10] == opaddr_pkg::SINGLE_PFX || instr[15:13] == 3'h1) begin
            iclass <= opaddr_pkg::IC_SINGLE;
            state <= S_OPND;
          end else begin
            iclass <= opaddr_pkg::IC_OTHER;
            state <= S_DONE;
          end
        end
        S_OPND: begin
          case (cur.kind)
            opaddr_pkg::OPK_REG: begin
              ea <= cur.reg_addr; // [RULE6]
              state <= S_OPND_END;
            end
            opaddr_pkg::OPK_SYM: begin
              mem_addr <= pc; // [RULE12] [RULE13]
              state <= S_EXT_RD;
            end
            default: begin
              mem_addr <= cur.reg_addr; // [RULE9] [RULE11]
              state <= S_REG_RD;
            end
          endcase
        end
        S_REG_RD: begin
          if (mem_rsp.ready) begin
            ea <= mem_rsp.rdata; // [RULE9] [RULE20]
            if (cur.kind == opaddr_pkg::OPK_AUTO) begin
              mem_wdata <= mem_rsp.rdata + cur.step; // [RULE10] [RULE20]
              state <= S_AUTO_WR;
            end else begin
              state <= S_OPND_END;
            end
          end
        end
        S_AUTO_WR: begin
          if (mem_rsp.ready) begin
            state <= S_OPND_END;
          end
        end
        S_EXT_RD: begin
          if (mem_rsp.ready) begin
            ea <= mem_rsp.rdata; // [RULE12]
            if (cur.indexed) begin
              mem_addr <= cur.reg_addr;
              state <= S_IDX_RD;
            end else begin
              state <= S_OPND_END;
            end
          end
        end
        S_IDX_RD: begin
          if (mem_rsp.ready) begin
            ea <= ea + mem_rsp.rdata; // [RULE14]
            state <= S_OPND_END;
          end
        end
        S_OPND_END: begin
          mem_addr <= ea_aligned; // [RULE16]
          if (!phase_dst) begin
            src_ea <= ea_aligned;
            state <= S_VAL_RD;
          end else begin
            dst_ea <= ea_aligned;
            mem_wdata <= byte_op ? {src_val[7:0], src_val[7:0]} : src_val;
            if (instr[opaddr_pkg::OP_HI:opaddr_pkg::OP_LO] == opaddr_pkg::COPY_OP && copy_en) begin
              state <= S_DST_WR; // [RULE17]
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_VAL_RD: begin
          if (mem_rsp.ready) begin
            src_val <= val_sel; // [RULE2] [RULE7]
            if (iclass == opaddr_pkg::IC_TWO_OP) begin
              phase_dst <= 1'b1; // [RULE13]
              state <= S_OPND;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_DST_WR: begin
          if (mem_rsp.ready) begin
            state <= S_DONE; // [RULE17]
          end
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Program counter: software may load it only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= opaddr_pkg::PC_RESET;
    end else if ((state == S_FETCH || state == S_EXT_RD) && mem_rsp.ready) begin
      pc <= pc + opaddr_pkg::WORD_STEP; // [RULE19]
    end else if (state == S_DONE && iclass == opaddr_pkg::IC_JUMP) begin
      pc <= target;
    end else if (do_write && aw_addr[7:2] == opaddr_pkg::OFF_PC[7:2] && !busy) begin
      pc <= merge16(pc, w_data[15:0], w_strb[1:0]);
    end
  end

  // Completion flag; a new completion wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
    end else if (state == S_DONE) begin
      done <= 1'b1;
    end else if (done_clr) begin
      done <= 1'b0;
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nv, input logic [1:0] strb);
    merge16 = {strb[1] ? nv[15:8] : old[15:8], strb[0] ? nv[7:0] : old[7:0]};
  endfunction

  // AXI4-Lite write path: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    case (aw_addr[7:2])
      opaddr_pkg::OFF_CTRL[7:2], opaddr_pkg::OFF_WP[7:2], opaddr_pkg::OFF_PC[7:2],
      opaddr_pkg::OFF_STATUS[7:2], opaddr_pkg::OFF_INSTR[7:2], opaddr_pkg::OFF_SRC_EA[7:2],
      opaddr_pkg::OFF_DST_EA[7:2], opaddr_pkg::OFF_SRC_VAL[7:2], opaddr_pkg::OFF_TARGET[7:2],
      opaddr_pkg::OFF_COUNT[7:2]: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= opaddr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? opaddr_pkg::RESP_OKAY : opaddr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-written control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= opaddr_pkg::WP_RESET;
      copy_en <= 1'b1;
      start_pulse <= 1'b0;
      done_clr <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      done_clr <= 1'b0;
      if (do_write && aw_addr[7:2] == opaddr_pkg::OFF_CTRL[7:2] && w_strb[0]) begin
        start_pulse <= w_data[opaddr_pkg::CTRL_START] && !busy;
        done_clr <= w_data[opaddr_pkg::CTRL_DONE_CLR];
        copy_en <= w_data[opaddr_pkg::CTRL_COPY_EN];
      end
      // Moving the workspace mid-instruction would split one operand across two bases
      if (do_write && aw_addr[7:2] == opaddr_pkg::OFF_WP[7:2] && !busy) begin
        wp <= merge16(wp, w_data[15:0], w_strb[1:0]); // [RULE18]
      end
    end
  end

  // AXI4-Lite read path
  always_comb begin
    rd_ok = 1'b1;
    case (ar_word)
      opaddr_pkg::OFF_CTRL[7:2]: rd_data = {29'h0, copy_en, 2'h0};
      opaddr_pkg::OFF_WP[7:2]: rd_data = {16'h0000, wp};
      opaddr_pkg::OFF_PC[7:2]: rd_data = {16'h0000, pc};
      opaddr_pkg::OFF_STATUS[7:2]: rd_data = {25'h0, iclass, 1'b0, byte_op, done, busy};
      opaddr_pkg::OFF_INSTR[7:2]: rd_data = {16'h0000, instr};
      opaddr_pkg::OFF_SRC_EA[7:2]: rd_data = {16'h0000, src_ea};
      opaddr_pkg::OFF_DST_EA[7:2]: rd_data = {16'h0000, dst_ea};
      opaddr_pkg::OFF_SRC_VAL[7:2]: rd_data = {16'h0000, src_val};
      opaddr_pkg::OFF_TARGET[7:2]: rd_data = {16'h0000, target};
      opaddr_pkg::OFF_COUNT[7:2]: rd_data = {28'h0, xfer_count};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign ar_word = {2'h0, s_axi_araddr[7:2]};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= opaddr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? opaddr_pkg::RESP_OKAY : opaddr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [opaddr_pkg.sv]
`default_nettype none
package opaddr_pkg;
  // Operand mode field encodings
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_SYM = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // Instruction word field positions, bit 15 is the leftmost bit
  localparam int OP_HI = 15;
  localparam int OP_LO = 13;
  localparam int BYTE_BIT = 12;
  localparam int DMODE_HI = 11;
  localparam int DMODE_LO = 10;
  localparam int DREG_HI = 9;
  localparam int DREG_LO = 6;
  localparam int SMODE_HI = 5;
  localparam int SMODE_LO = 4;
  localparam int SREG_HI = 3;
  localparam int SREG_LO = 0;
  localparam int DISP_HI = 7;
  localparam int DISP_LO = 0;
  localparam int BIO_CNT_HI = 9;
  localparam int BIO_CNT_LO = 6;
  localparam int SH_CNT_HI = 7;
  localparam int SH_CNT_LO = 4;

  // Opcode prefixes that classify the word
  localparam logic [1:0] SINGLE_FMT_TOP = 2'h0;
  localparam logic [3:0] JUMP_PFX = 4'h1;
  localparam logic [4:0] BIO_PFX = 5'h06;
  localparam logic [5:0] SHIFT_PFX = 6'h02;
  localparam logic [5:0] SINGLE_PFX = 6'h01;
  localparam logic [2:0] COPY_OP = 3'h6;

  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_MASK = 16'hfffe;
  localparam logic [3:0] NO_INDEX = 4'h0;

  // Register map, byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_WP = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_INSTR = 8'h10;
  localparam logic [7:0] OFF_SRC_EA = 8'h14;
  localparam logic [7:0] OFF_DST_EA = 8'h18;
  localparam logic [7:0] OFF_SRC_VAL = 8'h1c;
  localparam logic [7:0] OFF_TARGET = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;

  localparam int CTRL_START = 0;
  localparam int CTRL_DONE_CLR = 1;
  localparam int CTRL_COPY_EN = 2;
  localparam logic [15:0] WP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OPK_REG, OPK_IND, OPK_SYM, OPK_AUTO} opnd_kind_e;
  typedef enum logic [2:0] {IC_TWO_OP, IC_JUMP, IC_SINGLE, IC_BIT_IO, IC_SHIFT, IC_OTHER} instr_class_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic byte_op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic ready;
    logic [15:0] rdata;
  } mem_rsp_s;

  typedef struct packed {
    opnd_kind_e kind;
    logic [15:0] reg_addr;
    logic indexed;
    logic [15:0] step;
  } opnd_s;
endpackage
`default_nettype wire

// [operand_field_decoder.sv]
`default_nettype none
module operand_field_decoder (
  // Fields of one operand
  input wire logic [1:0] mode,
  input wire logic [3:0] regn,
  input wire logic byte_op,
  // Workspace base
  input wire logic [15:0] wp,
  // Decoded operand
  output opaddr_pkg::opnd_s info
);
  always_comb begin
    info.reg_addr = (wp & opaddr_pkg::WORD_MASK) + {11'h000, regn, 1'b0}; // [RULE21] [RULE18] [RULE3]
    info.step = byte_op ? opaddr_pkg::BYTE_STEP : opaddr_pkg::WORD_STEP; // [RULE10] [RULE16]
    info.indexed = 1'b0;
    case (mode) // [RULE1]
      opaddr_pkg::MODE_REG: info.kind = opaddr_pkg::OPK_REG; // [RULE6]
      opaddr_pkg::MODE_IND: info.kind = opaddr_pkg::OPK_IND;
      opaddr_pkg::MODE_AUTO: info.kind = opaddr_pkg::OPK_AUTO;
      default: begin
        info.kind = opaddr_pkg::OPK_SYM;
        info.indexed = (regn != opaddr_pkg::NO_INDEX); // [RULE14] [RULE15]
      end
    endcase
  end
endmodule
`default_nettype wire

// [operand_address_decoder_properties.sv]
`default_nettype none
module opaddr_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port
  input wire opaddr_pkg::mem_req_s mem_req,
  input wire opaddr_pkg::mem_rsp_s mem_rsp
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_MEM_HOLD: assert property (mem_req.valid && !mem_rsp.ready |=> mem_req.valid && $stable(mem_req.addr)
    && $stable(mem_req.wdata) && $stable(mem_req.write) && $stable(mem_req.byte_op))
    else $error("memory request changed before it was accepted");
  AST_WORD_EVEN: assert property (mem_req.valid && !mem_req.byte_op |-> !mem_req.addr[0])
    else $error("word access at odd address");
  AST_BYTE_LANES: assert property (mem_req.valid && mem_req.write && mem_req.byte_op |->
    mem_req.wdata[15:8] == mem_req.wdata[7:0])
    else $error("byte write data differs between lanes");
  AST_MEM_GAP: assert property (mem_req.valid && mem_req.write && mem_rsp.ready |=> !mem_req.valid)
    else $error("memory access right after a write");
  AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_ONE_READ: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
endmodule

bind operand_address_decoder opaddr_checker i_opaddr_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .mem_req(mem_req), .mem_rsp(mem_rsp));
`default_nettype wire

// [workspace_memory_model.sv]
`default_nettype none
module workspace_memory_model (
  // Clock
  input wire logic aclk,
  // Access port
  input wire opaddr_pkg::mem_req_s mem_req,
  output opaddr_pkg::mem_rsp_s mem_rsp,
  // Stall length in cycles
  input wire logic [1:0] wait_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:32767];
  logic [1:0] waited;
  logic [15:0] word;

  assign word = mem[mem_req.addr[15:1]];
  assign mem_rsp.ready = mem_req.valid && (waited >= wait_cycles);
  // Inverted data outside an answer so a stale sample never matches
  assign mem_rsp.rdata = (mem_rsp.ready && !mem_req.write) ? word : ~word;

  always @(posedge aclk) begin
    if (!mem_req.valid || mem_rsp.ready) begin
      waited <= 2'h0;
    end else if (waited != 2'h3) begin
      waited <= waited + 2'h1;
    end
  end

  // Even byte address is the left lane of its word
  always @(posedge aclk) begin
    if (mem_req.valid && mem_rsp.ready && mem_req.write) begin
      if (!mem_req.byte_op) begin
        mem[mem_req.addr[15:1]] <= mem_req.wdata;
      end else if (mem_req.addr[0]) begin
        mem[mem_req.addr[15:1]][7:0] <= mem_req.wdata[7:0];
      end else begin
        mem[mem_req.addr[15:1]][15:8] <= mem_req.wdata[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// [operand_address_decoder_test.sv]
`default_nettype none
module operand_address_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, wait_cycles;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  opaddr_pkg::mem_req_s mem_req;
  opaddr_pkg::mem_rsp_s mem_rsp;
  int fail_count = 0;
  int n_tests = 0;

  operand_address_decoder i_operand_address_decoder (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rsp(mem_rsp));
  workspace_memory_model i_mem (.aclk(aclk), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .wait_cycles(wait_cycles));

  always #5 aclk = ~aclk;

  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask

  // Ready follows the answer by a cycle, so the slave is seen holding it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      r = s_axi_bresp;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= s_axi_bvalid && !s_axi_bready;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= s_axi_rvalid && !s_axi_rready;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask = 32'hffff_ffff);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_resp(r, opaddr_pkg::RESP_OKAY);
    check_word(d & mask, exp);
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] v);
    i_mem.mem[a[15:1]] = v;
  endtask

  task automatic run_instr(input logic [15:0] wp, input logic [15:0] pc, input logic copy = 1'b1);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    axi_write(opaddr_pkg::OFF_WP, {16'h0000, wp}, r);
    axi_write(opaddr_pkg::OFF_PC, {16'h0000, pc}, r);
    axi_write(opaddr_pkg::OFF_CTRL, {29'h0, copy, 2'h1}, r);
    st = 32'h0;
    n = 0;
    while (st[1] !== 1'b1 && n < 100) begin
      axi_read(opaddr_pkg::OFF_STATUS, st, r);
      n++;
    end
    check_word({31'h0, st[1]}, 32'h1);
    axi_write(opaddr_pkg::OFF_CTRL, {29'h0, copy, 2'h2}, r);
  endtask

  task automatic test_reset_and_map;
    logic [31:0] d;
    logic [1:0] r;
    rd(opaddr_pkg::OFF_WP, 32'h0);
    rd(opaddr_pkg::OFF_STATUS, 32'h0, 32'h7);
    axi_read(8'h28, d, r);
    check_resp(r, opaddr_pkg::RESP_SLVERR);
    check_word(d, 32'h0);
    axi_write(8'h28, 32'h1, r);
    check_resp(r, opaddr_pkg::RESP_SLVERR);
    axi_write(opaddr_pkg::OFF_SRC_EA, 32'h1234, r);
    rd(opaddr_pkg::OFF_SRC_EA, 32'h0);
  endtask

  task automatic test_copy_registers;
    wait_cycles <= 2'h0;
    put(16'h0102, 16'h1234);
    put(16'h0108, 16'hffff);
    put(16'h0040, 16'hc101);
    run_instr(16'h0100, 16'h0040, 1'b0);
    check_word({16'h0, i_mem.mem[16'h0084]}, 32'hffff);
    run_instr(16'h0100, 16'h0040);
    check_word({16'h0, i_mem.mem[16'h0084]}, 32'h1234);
    rd(opaddr_pkg::OFF_SRC_EA, 32'h0102);
    rd(opaddr_pkg::OFF_DST_EA, 32'h0108);
    rd(opaddr_pkg::OFF_PC, 32'h0042);
  endtask

  task automatic test_autoinc_word;
    wait_cycles <= 2'h2;
    put(16'h0040, 16'hc531);
    put(16'h0102, 16'h0200);
    put(16'h0200, 16'habcd);
    put(16'h0108, 16'h0300);
    put(16'h0300, 16'h0000);
    run_instr(16'h0100, 16'h0040);
    check_word({16'h0, i_mem.mem[16'h0180]}, 32'habcd);
    check_word({16'h0, i_mem.mem[16'h0081]}, 32'h0202);
    check_word({16'h0, i_mem.mem[16'h0084]}, 32'h0300);
    rd(opaddr_pkg::OFF_SRC_EA, 32'h0200);
  endtask

  task automatic test_autoinc_byte;
    wait_cycles <= 2'h1;
    put(16'h0040, 16'hd0b1);
    put(16'h0102, 16'h0201);
    put(16'h0200, 16'habcd);
    put(16'h0104, 16'h1111);
    run_instr(16'h0100, 16'h0040);
    check_word({16'h0, i_mem.mem[16'h0082]}, 32'hcd11);
    check_word({16'h0, i_mem.mem[16'h0081]}, 32'h0202);
    rd(opaddr_pkg::OFF_SRC_VAL, 32'h00cd);
  endtask

  task automatic test_symbolic;
    wait_cycles <= 2'h1;
    put(16'h1000, 16'hc8e0);
    put(16'h1002, 16'h0400);
    put(16'h1004, 16'h0500);
    put(16'h0106, 16'h0006);
    put(16'h0400, 16'h5a5a);
    put(16'h0506, 16'h0000);
    run_instr(16'h0100, 16'h1000);
    rd(opaddr_pkg::OFF_SRC_EA, 32'h0400);
    rd(opaddr_pkg::OFF_DST_EA, 32'h0506);
    check_word({16'h0, i_mem.mem[16'h0283]}, 32'h5a5a);
    rd(opaddr_pkg::OFF_PC, 32'h1006);
  endtask

  task automatic test_jump_and_counts;
    logic [15:0] words [2] = '{16'h0a50, 16'h31c1};
    logic [31:0] cls [2] = '{32'h40, 32'h30};
    logic [31:0] cnt [2] = '{32'h5, 32'h7};
    wait_cycles <= 2'h0;
    put(16'h2000, 16'h10fe);
    run_instr(16'h0100, 16'h2000);
    rd(opaddr_pkg::OFF_TARGET, 32'h1ffe);
    rd(opaddr_pkg::OFF_PC, 32'h1ffe);
    for (int i = 0; i < 2; i++) begin
      put(16'h0040, words[i]);
      run_instr(16'h0100, 16'h0040);
      rd(opaddr_pkg::OFF_COUNT, cnt[i]);
      rd(opaddr_pkg::OFF_STATUS, cls[i], 32'h70);
    end
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    wait_cycles = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset_and_map();
    test_copy_registers();
    test_autoinc_word();
    test_autoinc_byte();
    test_symbolic();
    test_jump_and_counts();
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (50000) @(posedge aclk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
